/* rtl/cmcl_charge_ctrl.sv */
// Charge mode controller: fast/trickle state machine, timers and register slave
`timescale 1ns/1ns
module cmcl_charge_ctrl
  import cmcl_pkg::*;
#(
  parameter longint unsigned HOLDOFF_CNT = HOLDOFF_CYCLES,
  parameter longint unsigned SAMPLE_CNT  = SAMPLE_CYCLES,
  parameter longint unsigned TICK_CNT    = TIMER_TICK_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Comparator results
  input  wire logic        sense_low_i,
  input  wire logic        sense_high_i,
  input  wire logic        neg_slope_i,
  input  wire logic        timer_sel_i,
  input  wire logic        prog_in_low_ref_i,
  input  wire logic        prog_in_sense_i,
  input  wire logic        prog_in_high_ref_i,
  input  wire logic        high_ref_neg_i,
  input  wire logic        temp_below_i,
  input  wire logic        temp_above_i,
  input  wire logic        uvlo_i,
  // Charger outputs
  output logic             fast_o,
  output logic             sample_gate_o,
  output logic             irq_o,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o
);

  localparam int unsigned TW = TIMER_STAGES + 1;  // Extra stage keeps the final carry

  // Counters must be able to reach their terminal values
  if (HOLDOFF_CNT < 1 || HOLDOFF_CNT > 64'hffff_ffff || SAMPLE_CNT < 64 ||
      SAMPLE_CNT > 64'hffff_ffff || TICK_CNT < 1 || TICK_CNT > 64'hffff) begin : g_chk
    $error("cmcl_charge_ctrl: counter parameter out of range");
  end

  // Limit decode used by the timer compare; the timer read shows the top 32 bits of the raw count
  function automatic logic limit_hit(input logic [TW-1:0] cnt, input logic [2:0] code);
    limit_hit = cnt[TW-1:LIMIT_SHIFT] > {1'b0, code};
  endfunction

  cmcl_cmp_s   cmp;
  cmcl_state_e state;
  cmcl_state_e next_state;
  logic        in_window;
  logic        in_window_d;
  logic        uvlo_d;
  logic        reset_pulse;
  logic        eoc_latch;
  logic        timer_latch;
  logic        ot_latch;
  logic        latched;
  logic        permit_fast;
  logic        sw1_hold;
  logic        sw1;
  logic        sw2;
  logic        speed3;
  logic [TW-1:0] timer_cnt;
  logic [15:0] tick_cnt;
  logic        tick;
  logic [32:0] holdoff_cnt;
  logic        holdoff_done;
  logic [31:0] sample_cnt;
  logic [32:0] sample_next;
  logic        sample_tick;
  logic [1:0]  slope_cnt;
  logic        timer_expired;
  logic        charge_enable;
  logic        restart;
  logic [IRQ_W-1:0] irq_status;
  logic [IRQ_W-1:0] irq_mask;
  logic [IRQ_W-1:0] irq_event;
  logic        bus_req;
  logic        bus_wr;
  logic        bus_rd;
  logic [31:0] status_word;

  // Register every comparator result once so the logic sees one stable sample
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cmp <= '0;
    end else begin
      cmp.sense_low    <= sense_low_i;
      cmp.sense_high   <= sense_high_i;
      cmp.neg_slope    <= neg_slope_i;
      cmp.timer_sel    <= timer_sel_i;
      cmp.prog_code    <= {prog_in_low_ref_i, prog_in_sense_i, prog_in_high_ref_i};
      cmp.high_ref_neg <= high_ref_neg_i;
      cmp.temp_below   <= temp_below_i;
      cmp.temp_above   <= temp_above_i;
      cmp.uvlo         <= uvlo_i;
    end
  end

  // Window and reset pulse sources
  assign in_window   = !cmp.sense_low && !cmp.sense_high;
  assign reset_pulse = (in_window && !in_window_d) || (uvlo_d && !cmp.uvlo)
                       || restart;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      in_window_d <= 1'b0;
      uvlo_d      <= 1'b0;
    end else begin
      in_window_d <= in_window;
      uvlo_d      <= cmp.uvlo;
    end
  end

  // Test switches; mode entry needs no extra pins, only the analog levels
  assign sw2    = cmp.sense_low && cmp.high_ref_neg;
  assign sw1    = cmp.sense_low && !cmp.high_ref_neg;
  assign speed3 = cmp.high_ref_neg;

  // Prescaler for the backup timer base rate
  always_ff @(posedge clk_i) begin
    if (rst_i || cmp.uvlo || reset_pulse) begin
      tick_cnt <= '0;
    end else if (tick) begin
      tick_cnt <= '0;
    end else if (state == CMCL_FAST) begin
      tick_cnt <= tick_cnt + 16'h0001;
    end
  end
  assign tick = (state == CMCL_FAST) && (tick_cnt == 16'(TICK_CNT - 1));

  // Backup timer chain; bypassed stages become a larger step per tick
  always_ff @(posedge clk_i) begin
    if (rst_i || cmp.uvlo || reset_pulse) begin
      timer_cnt <= '0;
    end else if (tick && !timer_cnt[TW-1]) begin
      if (sw1) begin
        timer_cnt <= timer_cnt + (TW'(1) << SW1_BYPASS);
      end else if (sw2) begin
        timer_cnt <= timer_cnt + (TW'(1) << SW2_BYPASS);
      end else begin
        timer_cnt <= timer_cnt + TW'(1);
      end
    end
  end
  assign timer_expired = cmp.timer_sel && limit_hit(timer_cnt, cmp.prog_code);

  // Holdoff after fast start, sped up with the sampling divider
  always_ff @(posedge clk_i) begin
    if (rst_i || state != CMCL_FAST) begin
      holdoff_cnt <= '0;
    end else if (!holdoff_done) begin
      if (speed3) begin
        holdoff_cnt <= holdoff_cnt + (33'(1) << HOLDOFF_BYPASS);
      end else begin
        holdoff_cnt <= holdoff_cnt + 33'h0_0000_0001;
      end
    end
  end
  assign holdoff_done = holdoff_cnt >= 33'(HOLDOFF_CNT);

  // Sample gate divider: one strobe per sampling period
  always_ff @(posedge clk_i) begin
    if (rst_i || sample_tick) begin
      sample_cnt <= '0;
    end else if (speed3) begin
      sample_cnt <= sample_cnt + (32'(1) << SAMPLE_BYPASS);
    end else begin
      sample_cnt <= sample_cnt + 32'h0000_0001;
    end
  end
  // Strobe on the step that reaches the period, so a sped-up divider keeps an exact ratio
  assign sample_next = {1'b0, sample_cnt}
                       + (speed3 ? (33'(1) << SAMPLE_BYPASS) : 33'h0_0000_0001);
  assign sample_tick = sample_next >= 33'(SAMPLE_CNT);

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      sample_gate_o <= 1'b0;
    end else begin
      sample_gate_o <= sample_tick;
    end
  end

  // Consecutive slope drops; a sample without a drop starts the count over
  always_ff @(posedge clk_i) begin
    if (rst_i || state != CMCL_FAST || !holdoff_done) begin
      slope_cnt <= 2'h0;
    end else if (sample_tick) begin
      if (!cmp.neg_slope) begin
        slope_cnt <= 2'h0;
      end else if (slope_cnt != 2'h2) begin
        slope_cnt <= slope_cnt + 2'h1;
      end
    end
  end

  // End of charge latch; set wins over a same-cycle reset pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      eoc_latch <= 1'b0;
    end else if (state == CMCL_FAST && slope_cnt == 2'h2) begin
      eoc_latch <= 1'b1;
    end else if (reset_pulse) begin
      eoc_latch <= 1'b0;
    end
  end

  // Timer expiry latch
  // Lockout clears it directly, so a supply dip always restarts the backup time
  always_ff @(posedge clk_i) begin
    if (rst_i || cmp.uvlo) begin
      timer_latch <= 1'b0;
    end else if (state == CMCL_FAST && timer_expired) begin
      timer_latch <= 1'b1;
    end else if (reset_pulse) begin
      timer_latch <= 1'b0;
    end
  end

  // Overtemperature latch; still hot at the pulse means it sets again
  always_ff @(posedge clk_i) begin
    if (rst_i || cmp.uvlo) begin
      ot_latch <= 1'b0;
    end else if (!cmp.timer_sel && cmp.temp_above) begin
      ot_latch <= 1'b1;
    end else if (reset_pulse) begin
      ot_latch <= 1'b0;
    end
  end

  assign latched = eoc_latch || timer_latch || ot_latch;

  // Fast is allowed only when every guard agrees; heat drops fast at once and the
  // latch, set on the same edge, keeps it down until a reset pulse
  assign permit_fast = in_window && !cmp.uvlo && !latched && charge_enable
                       && (cmp.timer_sel || !cmp.temp_below)
                       && (cmp.timer_sel || !cmp.temp_above);
  // Sense dropping low in timer mode keeps fast until the sped-up limit ends it
  assign sw1_hold = cmp.sense_low && cmp.timer_sel && !cmp.uvlo && !latched
                    && charge_enable;

  // Mode state machine
  always_comb begin
    next_state = state;
    case (state)
      CMCL_TRICKLE: begin
        if (latched) begin
          next_state = CMCL_LATCHED;
        end else if (permit_fast && !reset_pulse) begin
          next_state = CMCL_FAST;
        end
      end
      CMCL_FAST: begin
        if (latched || cmp.uvlo) begin
          next_state = latched ? CMCL_LATCHED : CMCL_TRICKLE;
        end else if (!permit_fast && !sw1_hold) begin
          next_state = CMCL_TRICKLE;
        end
      end
      CMCL_LATCHED: begin
        if (!latched) begin
          next_state = CMCL_TRICKLE;
        end
      end
      default: next_state = CMCL_TRICKLE;
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= CMCL_TRICKLE;
    end else begin
      state <= next_state;
    end
  end

  // Output register follows the state so the pin never glitches
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      fast_o <= 1'b0;
    end else begin
      fast_o <= (next_state == CMCL_FAST);
    end
  end

  // Interrupt events
  assign irq_event[IRQ_FAST]  = (next_state == CMCL_FAST) && (state != CMCL_FAST);
  assign irq_event[IRQ_EOC]   = (state == CMCL_FAST) && (slope_cnt == 2'h2) && !eoc_latch;
  assign irq_event[IRQ_TIMER] = (state == CMCL_FAST) && timer_expired && !timer_latch;
  assign irq_event[IRQ_OT]    = !cmp.timer_sel && cmp.temp_above && !ot_latch && !cmp.uvlo;
  assign irq_event[IRQ_UVLO]  = cmp.uvlo && !uvlo_d;

  // Wishbone decode; ack one cycle after the strobe, dropped for a cycle after
  assign bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign bus_wr  = bus_req && wb_we_i;
  assign bus_rd  = bus_req && !wb_we_i;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  // Control register; restart is a self-clearing pulse
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      charge_enable <= CTRL_ENABLE_RST;
      restart       <= 1'b0;
    end else begin
      restart <= 1'b0;
      if (bus_wr && wb_adr_i == CTRL_OFS && wb_sel_i[0]) begin
        charge_enable <= wb_dat_i[CTRL_ENABLE_BIT];
        restart       <= wb_dat_i[CTRL_RESTART_BIT];
      end
    end
  end

  // Interrupt mask
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= IRQ_MASK_RST;
    end else if (bus_wr && wb_adr_i == IRQ_MASK_OFS && wb_sel_i[0]) begin
      irq_mask <= wb_dat_i[IRQ_W-1:0];
    end
  end

  // Sticky status, cleared by a read; a new event in that cycle survives
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_status <= '0;
    end else if (bus_rd && wb_adr_i == IRQ_STATUS_OFS) begin
      irq_status <= irq_event;
    end else begin
      irq_status <= irq_status | irq_event;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |((irq_status | irq_event) & irq_mask);
    end
  end

  // Status snapshot; slope count and holdoff show how far end-of-charge detection got
  assign status_word = {22'h00_0000, slope_cnt, holdoff_done, cmp.uvlo, cmp.timer_sel,
                        in_window, ot_latch, timer_latch, eoc_latch, fast_o};

  // Read data register; unmapped offsets answer with zero
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= '0;
    end else if (bus_rd) begin
      case (wb_adr_i)
        CTRL_OFS:       wb_dat_o <= {31'h0000_0000, charge_enable};
        STATUS_OFS:     wb_dat_o <= status_word;
        IRQ_STATUS_OFS: wb_dat_o <= {27'h000_0000, irq_status};
        IRQ_MASK_OFS:   wb_dat_o <= {27'h000_0000, irq_mask};
        TIMER_OFS:      wb_dat_o <= timer_cnt[TW-1:TW-32];
        default:        wb_dat_o <= '0;
      endcase
    end
  end

endmodule

/* rtl/cmcl_pkg.sv */
// Package: constants, register map and types of the charge mode controller
// Behaviour
// - Entering the sense window selects fast mode and pulses the reset.
// - Two consecutive slope drops after the holdoff latch trickle mode.
// - Latched trickle clears only on a window entry, supply recovery or restart reset pulse, or lockout for timer and temperature latches.
// - Sense above its window, or below it with temperature backup, selects trickle mode.
// - Backup timer past its programmed limit latches trickle mode.
// - Fast entered only with sense in window, supply good, selected backup within limits.
// - Under-temperature holds trickle unlatched, fast resumes once limit exceeded.
// - Over-temperature latches trickle until a reset pulse is applied and released.
// - Supply lockout forces trickle and holds timer and temperature latch reset.
// - Backup timer is a 34-stage divider, longest limit 283 minutes.
// - Sense below window bypasses 19 timer stages, 524288-fold faster.
// - In that mode fast output falls after the sped-up programmed limit.
// - Sense low plus negative high-ref bypasses 11 stages, 2048-fold faster.
// - In that mode fast output falls after the sped-up timer delay.
// - Negative high-ref speeds the sense sampling divider 32-fold.
// - Negative high-ref speeds the holdoff timer 2048-fold.
// - Both sampling and holdoff speedups come on together from negative high-ref.
// - Three programming inputs pick seven limits, all low selects temperature backup.
package cmcl_pkg;

  // Clock and timing
  localparam longint unsigned CLK_HZ            = 64'd25_000_000;
  localparam longint unsigned TIMER_FULL_MIN    = 64'd283;
  localparam int unsigned     TIMER_STAGES      = 34;
  localparam longint unsigned TIMER_TICK_CYCLES =
    (TIMER_FULL_MIN * 64'd60 * CLK_HZ) >> TIMER_STAGES;   // Longest time: rounds down
  localparam longint unsigned HOLDOFF_S         = 64'd160;
  localparam longint unsigned HOLDOFF_CYCLES    = HOLDOFF_S * CLK_HZ;
  localparam longint unsigned SAMPLE_MS         = 64'd1380;
  localparam longint unsigned SAMPLE_CYCLES     = SAMPLE_MS * CLK_HZ / 64'd1000;

  // Divider bypass widths
  localparam int unsigned SW1_BYPASS     = 19;
  localparam int unsigned SW2_BYPASS     = 11;
  localparam int unsigned SAMPLE_BYPASS  = 5;
  localparam int unsigned HOLDOFF_BYPASS = 11;
  localparam int unsigned LIMIT_SHIFT    = 31;

  // Register byte offsets
  localparam logic [7:0] CTRL_OFS       = 8'h00;
  localparam logic [7:0] STATUS_OFS     = 8'h04;
  localparam logic [7:0] IRQ_STATUS_OFS = 8'h08;
  localparam logic [7:0] IRQ_MASK_OFS   = 8'h0c;
  localparam logic [7:0] TIMER_OFS      = 8'h10;

  // Control fields and reset values
  localparam int unsigned CTRL_ENABLE_BIT  = 0;
  localparam int unsigned CTRL_RESTART_BIT = 1;
  localparam logic        CTRL_ENABLE_RST  = 1'b1;
  localparam logic [4:0]  IRQ_MASK_RST     = 5'h00;

  // Interrupt event positions
  localparam int unsigned IRQ_FAST  = 0;
  localparam int unsigned IRQ_EOC   = 1;
  localparam int unsigned IRQ_TIMER = 2;
  localparam int unsigned IRQ_OT    = 3;
  localparam int unsigned IRQ_UVLO  = 4;
  localparam int unsigned IRQ_W     = 5;

  // Comparator results from the analog front end
  typedef struct packed {
    logic       sense_low;     // Sense below 1.0 V
    logic       sense_high;    // Sense above 2.0 V
    logic       neg_slope;     // Slope detector saw a drop in this sample
    logic       timer_sel;     // Any programming input open: timer backup
    logic [2:0] prog_code;     // {low_ref, sense, high_ref}, open reads 1
    logic       high_ref_neg;  // High-ref programming input at -100 mV
    logic       temp_below;    // Temperature below lower limit
    logic       temp_above;    // Temperature above upper limit
    logic       uvlo;          // Supply undervoltage lockout active
  } cmcl_cmp_s;

  typedef enum logic [2:0] {
    CMCL_TRICKLE = 3'b001,
    CMCL_FAST    = 3'b010,
    CMCL_LATCHED = 3'b100
  } cmcl_state_e;

endpackage

/* verification/cmcl_charge_ctrl_assertions.sv */
// Checker: port-level properties of the charge mode controller
`timescale 1ns/1ns
module cmcl_charge_ctrl_assertions
  import cmcl_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        sense_low_i,
  input wire logic        sense_high_i,
  input wire logic        timer_sel_i,
  input wire logic        temp_below_i,
  input wire logic        temp_above_i,
  input wire logic        uvlo_i,
  input wire logic        fast_o,
  input wire logic        sample_gate_o,
  input wire logic        irq_o,
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic        wb_we_i,
  input wire logic [7:0]  wb_adr_i,
  input wire logic [3:0]  wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic        wb_ack_o
);
  logic       in_win;
  logic       ok_now;
  logic       en_q;
  logic [4:0] mask_q;
  logic [3:0] win_age;

  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  // Window and supply guard as seen at the pins
  assign in_win = !sense_low_i && !sense_high_i;
  assign ok_now = in_win && !uvlo_i;

  // Shadows lag the design by a cycle, so checks on them leave slack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      en_q   <= CTRL_ENABLE_RST;
      mask_q <= IRQ_MASK_RST;
    end else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == CTRL_OFS) begin
      en_q <= wb_dat_i[CTRL_ENABLE_BIT];
    end else if (wb_ack_o && wb_we_i && wb_sel_i[0] && wb_adr_i == IRQ_MASK_OFS) begin
      mask_q <= wb_dat_i[4:0];
    end
  end

  // Steady timer-mode conditions with no bus write: no reset pulse can occur
  always_ff @(posedge clk_i) begin
    if (rst_i || !ok_now || !timer_sel_i || !en_q || (wb_ack_o && wb_we_i)) begin
      win_age <= 4'h0;
    end else if (win_age != 4'hf) begin
      win_age <= win_age + 4'h1;
    end
  end

  AST_SENSE_OUT: assert property ((sense_high_i || (sense_low_i && !timer_sel_i))
    |-> ##2 !fast_o) else $error("fast kept with sense outside window");
  AST_UVLO_TRICKLE: assert property (uvlo_i |-> ##2 !fast_o)
    else $error("fast kept during lockout");
  AST_COLD_HOLD: assert property (!timer_sel_i && temp_below_i |-> ##2 !fast_o)
    else $error("fast kept while too cold");
  AST_HOT_TRIP: assert property (!timer_sel_i && temp_above_i |-> ##2 !fast_o)
    else $error("fast kept while too hot");
  AST_FAST_GUARD: assert property ($rose(fast_o) |-> $past(ok_now, 2))
    else $error("fast entered without window and supply");
  AST_ENTRY_FAST: assert property ($rose(in_win) && timer_sel_i && !uvlo_i && en_q
    |-> ##[1:4] fast_o) else $error("window entry gave no fast mode");
  AST_LATCH_HOLD: assert property (win_age >= 4'h8 && !fast_o |=> !fast_o)
    else $error("trickle left without a reset pulse");
  AST_ACK_TURN: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered next cycle");
  AST_ACK_ONCE: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  AST_IRQ_MASKED: assert property (mask_q == 5'h00 && $past(mask_q) == 5'h00 |-> !irq_o)
    else $error("interrupt with all sources masked");
  AST_GATE_PULSE: assert property (sample_gate_o |=> !sample_gate_o)
    else $error("sample gate wider than one cycle");

  cover property ($rose(fast_o));
  cover property ($fell(fast_o) && in_win);
  cover property ($rose(irq_o));
endmodule

bind cmcl_charge_ctrl cmcl_charge_ctrl_assertions chk (
  .clk_i(clk_i), .rst_i(rst_i), .sense_low_i(sense_low_i), .sense_high_i(sense_high_i),
  .timer_sel_i(timer_sel_i), .temp_below_i(temp_below_i), .temp_above_i(temp_above_i),
  .uvlo_i(uvlo_i), .fast_o(fast_o), .sample_gate_o(sample_gate_o), .irq_o(irq_o),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o)
);

/* verification/cmcl_pack_model.sv */
// Behavioural battery pack and power stage feeding the comparator inputs
`timescale 1ns/1ns
module cmcl_pack_model (
  input  wire logic       clk_i,
  input  wire logic [7:0] sense_dv_i,  // Divided pack voltage, 100 mV steps
  input  wire logic [7:0] vcc_dv_i,    // Supply, 100 mV steps
  input  wire logic [1:0] temp_i,      // 0 normal, 1 cold, 2 hot
  input  wire logic       full_i,      // Pack at full charge
  input  wire logic       fast_i,      // Fast current flowing
  output logic            sense_low_o  = 1'b1,
  output logic            sense_high_o = 1'b0,
  output logic            neg_slope_o  = 1'b0,
  output logic            temp_below_o = 1'b0,
  output logic            temp_above_o = 1'b0,
  output logic            uvlo_o       = 1'b0
);
  // Comparators settle just after the edge, never racing the design
  always @(posedge clk_i) begin
    sense_low_o  <= sense_dv_i < 8'h0a;
    sense_high_o <= sense_dv_i > 8'h14;
    temp_below_o <= temp_i == 2'h1;
    temp_above_o <= temp_i == 2'h2;
  end
  // A full pack sags under fast current, so the detector sees a drop
  always @(posedge clk_i) begin
    neg_slope_o <= full_i && fast_i;
  end
  // Lockout with hysteresis: set below 2.8 V, cleared above 3.0 V
  always @(posedge clk_i) begin
    if (vcc_dv_i < 8'h1c) begin
      uvlo_o <= 1'b1;
    end else if (vcc_dv_i > 8'h1e) begin
      uvlo_o <= 1'b0;
    end
  end
endmodule

/* verification/test_cmcl_charge_ctrl.sv */
// Self-checking bench for the charge mode controller
`timescale 1ns/1ns
module test_cmcl_charge_ctrl;
  import cmcl_pkg::*;
  localparam longint unsigned TICK = 64'h1;
  localparam longint unsigned SAMPLE = 64'h40;
  logic        clk_i     = 1'b0;
  logic        rst_i     = 1'b1;
  logic        timer_sel = 1'b1;
  logic [2:0]  prog      = 3'h7;
  logic        cyc       = 1'b0;
  logic        stb       = 1'b0;
  logic        we        = 1'b0;
  logic [7:0]  adr       = 8'h00;
  logic [31:0] wdat      = 32'h0;
  logic [7:0]  sense_dv  = 8'h05;
  logic [7:0]  vcc_dv    = 8'h32;
  logic [1:0]  temp      = 2'h0;
  logic        full      = 1'b0;
  logic        hrn       = 1'b0;
  logic [31:0] rd;
  logic [31:0] dato;
  logic        sl, sh, ns, tc, th, uv, fast, irq, ack, gate;
  int          n_errors  = 0;
  int          n_tests   = 0;

  always #20 clk_i = ~clk_i;

  cmcl_pack_model pack (.clk_i(clk_i), .sense_dv_i(sense_dv), .vcc_dv_i(vcc_dv),
    .temp_i(temp), .full_i(full), .fast_i(fast), .sense_low_o(sl), .sense_high_o(sh),
    .neg_slope_o(ns), .temp_below_o(tc), .temp_above_o(th), .uvlo_o(uv));

  cmcl_charge_ctrl #(.HOLDOFF_CNT(64'h64), .SAMPLE_CNT(SAMPLE), .TICK_CNT(TICK)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .sense_low_i(sl), .sense_high_i(sh), .neg_slope_i(ns),
    .timer_sel_i(timer_sel), .prog_in_low_ref_i(prog[2]), .prog_in_sense_i(prog[1]),
    .prog_in_high_ref_i(prog[0]), .high_ref_neg_i(hrn), .temp_below_i(tc),
    .temp_above_i(th), .uvlo_i(uv), .fast_o(fast), .sample_gate_o(gate), .irq_o(irq),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
    .wb_dat_i(wdat), .wb_dat_o(dato), .wb_ack_o(ack));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask

  task automatic cyc_n(input int n);
    repeat (n) @(posedge clk_i);
  endtask

  // One classic cycle; request held until ack is sampled high
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    @(posedge clk_i);
    while (ack !== 1'b1) @(posedge clk_i);
    rd = dato;
    cyc <= 1'b0;
    stb <= 1'b0;
    we  <= 1'b0;
  endtask

  task automatic t_regs();
    wb(1'b0, CTRL_OFS, 32'h0);
    chk(rd, 32'h1);
    wb(1'b0, IRQ_MASK_OFS, 32'h0);
    chk(rd, 32'h0);
    wb(1'b1, 8'h20, 32'hffffffff);
    wb(1'b0, 8'h20, 32'h0);
    chk(rd, 32'h0);
    chk(fast, 1'b0);
  endtask

  task automatic t_window();
    sense_dv <= 8'h0f;
    cyc_n(8);
    chk(fast, 1'b1);
    sense_dv <= 8'h19;
    cyc_n(6);
    chk(fast, 1'b0);
    sense_dv <= 8'h0f;
    cyc_n(8);
    chk(fast, 1'b1);
    wb(1'b1, CTRL_OFS, 32'h0);
    cyc_n(6);
    chk(fast, 1'b0);
    wb(1'b1, CTRL_OFS, 32'h3);
    cyc_n(8);
    chk(fast, 1'b1);
  endtask

  // End of charge latches, raises the unmasked interrupt, clears on read
  task automatic t_eoc();
    wb(1'b1, IRQ_MASK_OFS, 32'h2);
    wb(1'b0, IRQ_STATUS_OFS, 32'h0);
    full <= 1'b1;
    cyc_n(40);
    chk(fast, 1'b1);
    for (int i = 0; i < 400 && fast !== 1'b0; i++) cyc_n(1);
    chk(fast, 1'b0);
    full <= 1'b0;
    cyc_n(4);
    chk(irq, 1'b1);
    wb(1'b0, IRQ_STATUS_OFS, 32'h0);
    chk(rd & 32'h2, 32'h2);
    cyc_n(200);
    chk({irq, fast}, 2'b00);
    sense_dv <= 8'h19;
    cyc_n(4);
    sense_dv <= 8'h0f;
    cyc_n(8);
    chk({irq, fast}, 2'b01);
  endtask

  task automatic t_temp();
    timer_sel <= 1'b0;
    prog      <= 3'h0;
    wb(1'b1, CTRL_OFS, 32'h3);
    cyc_n(8);
    chk(fast, 1'b1);
    temp <= 2'h1;
    cyc_n(6);
    chk(fast, 1'b0);
    temp <= 2'h0;
    cyc_n(8);
    chk(fast, 1'b1);
    temp <= 2'h2;
    cyc_n(6);
    chk(fast, 1'b0);
    temp <= 2'h0;
    cyc_n(20);
    chk(fast, 1'b0);
    sense_dv <= 8'h19;
    cyc_n(4);
    sense_dv <= 8'h0f;
    cyc_n(8);
    chk(fast, 1'b1);
  endtask

  task automatic t_uvlo();
    timer_sel <= 1'b1;
    prog      <= 3'h7;
    vcc_dv    <= 8'h14;
    cyc_n(6);
    chk(fast, 1'b0);
    wb(1'b0, TIMER_OFS, 32'h0);
    chk(rd, 32'h0);
    vcc_dv <= 8'h32;
    cyc_n(8);
    chk(fast, 1'b1);
  endtask

  // Sense below window: limit runs sped up, fast holds then falls
  task automatic t_timer(input logic [2:0] code);
    int exp_cyc;
    exp_cyc = int'((code + 1) * (64'h1 << (LIMIT_SHIFT - SW1_BYPASS)) * TICK);
    prog <= code;
    wb(1'b1, CTRL_OFS, 32'h3);
    cyc_n(8);
    chk(fast, 1'b1);
    sense_dv <= 8'h05;
    cyc_n(exp_cyc - 64);
    chk(fast, 1'b1);
    cyc_n(128);
    chk(fast, 1'b0);
    sense_dv <= 8'h0f;
    cyc_n(8);
    chk(fast, 1'b1);
  endtask

  // Cycles between two sample gate strobes
  task automatic gate_period(output int n);
    n = 0;
    while (gate !== 1'b1) cyc_n(1);
    cyc_n(1);
    n = 1;
    while (gate !== 1'b1 && n < 200) begin
      cyc_n(1);
      n++;
    end
  endtask

  // Negative high-ref: faster sampling and holdoff; sense low then steps the timer by 2^11
  task automatic t_speed();
    int          p;
    logic [31:0] t0;
    gate_period(p);
    chk(p, 32'(SAMPLE));
    hrn <= 1'b1;
    sense_dv <= 8'h19;
    cyc_n(4);
    sense_dv <= 8'h0f;
    cyc_n(8);
    wb(1'b0, STATUS_OFS, 32'h0);
    chk(rd & 32'h81, 32'h81);
    gate_period(p);
    chk(p, 32'(SAMPLE >> SAMPLE_BYPASS));
    sense_dv <= 8'h05;
    cyc_n(4);
    wb(1'b0, TIMER_OFS, 32'h0);
    t0 = rd;
    wb(1'b0, TIMER_OFS, 32'h0);
    chk(rd - t0, 32'(3) << (SW2_BYPASS - 3));
    chk(fast, 1'b1);
  endtask

  task automatic end_of_test();
    if (n_errors == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // Tests take about 38000 cycles; the watchdog allows 60000
  initial begin
    cyc_n(60000);
    n_errors++;
    end_of_test();
  end

  initial begin
    cyc_n(4);
    rst_i <= 1'b0;
    t_regs();
    t_window();
    t_eoc();
    t_temp();
    t_uvlo();
    t_timer(3'h1);
    t_timer(3'h6);
    t_speed();
    end_of_test();
  end
endmodule
